// ---- core/ipcvs_ctrl.sv ----
// Priority configuration registers, arbitration of twelve sources and pending
// vector status, with an AHB-Lite register slave and an event interrupt.
// Assumes source request inputs are flag-and-enable already, synchronous to i_clk_sys.
//
// Functional notes
// - Each priority field is three bits; code 111 means level 7, the highest.
// - Code 001 gives the lowest active user level, level 1.
// - Code 000 disables the source; it is never forwarded to the processor.
// - Unimplemented bits of priority and status registers read zero, ignore writes.
// - Register 13: can_b_rx 14-12, ext four 10-8, ext three 6-4, timer nine 2-0.
// - Register 14 holds only can_b_event at bits 2-0.
// - Register 15 holds only dma channel five at bits 6-4.
// - Register 16: uart_b error at 10-8, uart_a error at 6-4.
// - Register 17: can_b_tx 14-12, can_a_tx 10-8, dma seven 6-4, dma six 2-0.
// - Status holds read-only 4-bit new CPU level; 1111 is level 15.
// - Status holds read-only 7-bit pending vector field; 1111111 is vector 135.
// - Pending vector field equals vector number minus eight.
// - Every priority field resets to level 4.
//
// The placing of the registers and register access over AHB-Lite were decided locally.
module ipcvs_ctrl #(
   parameter logic [ipcvs_pkg::NUM_SRC-1:0][7:0] P_SRC_VECTOR =
      {8'h33, 8'h32, 8'h31, 8'h30, 8'h2f, 8'h2e,
       8'h2d, 8'h2c, 8'h2b, 8'h2a, 8'h29, 8'h28}
) (
   input  wire logic                          i_clk_sys,
   input  wire logic                          i_rst,
   input  wire logic                          i_hsel,
   input  wire logic [31:0]                   i_haddr,
   input  wire logic [1:0]                    i_htrans,
   input  wire logic                          i_hwrite,
   input  wire logic [2:0]                    i_hsize,
   input  wire logic [31:0]                   i_hwdata,
   input  wire logic                          i_hready,
   output logic                               o_hreadyout,
   output logic                               o_hresp,
   output logic [31:0]                        o_hrdata,
   input  wire logic [ipcvs_pkg::NUM_SRC-1:0] i_src_req,
   output ipcvs_pkg::ipcvs_irq_type           o_irq,
   output logic                               o_int
);

   logic [ipcvs_pkg::NUM_PRIO_REGS-1:0][ipcvs_pkg::REG_W-1:0] prio_ff;
   logic [ipcvs_pkg::NUM_SRC-1:0][ipcvs_pkg::PRIO_W-1:0]      src_prio;
   logic [ipcvs_pkg::NUM_SRC-1:0]                             src_live;
   ipcvs_pkg::ipcvs_acc_type                                  acc_ff;
   ipcvs_pkg::ipcvs_acc_type                                  nxt_acc;
   ipcvs_pkg::ipcvs_irq_type                                  irq_ff;
   ipcvs_pkg::ipcvs_irq_type                                  nxt_irq;
   logic [ipcvs_pkg::LEVEL_W-1:0]                             stat_level_ff;
   logic [ipcvs_pkg::VEC_W-1:0]                               stat_vec_ff;
   logic [ipcvs_pkg::EVT_W-1:0]                               evt_ff;
   logic [ipcvs_pkg::EVT_W-1:0]                               evt_mask_ff;
   logic [ipcvs_pkg::EVT_W-1:0]                               evt_set;
   logic [31:0]                                               hrdata_ff;
   logic [31:0]                                               nxt_rdata;
   logic                                                      wr_en;
   logic                                                      new_irq;

   // Address phase capture; zero wait states
   always_comb
   begin
      nxt_acc.valid = i_hsel && i_hready && (i_htrans == ipcvs_pkg::HTRANS_NONSEQ);
      nxt_acc.write = i_hwrite;
      nxt_acc.addr  = i_haddr[7:0];
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         acc_ff <= '0;
      end
      else
      begin
         acc_ff <= nxt_acc;
      end
   end

   assign wr_en       = acc_ff.valid && acc_ff.write;
   assign o_hreadyout = 1'b1;
   assign o_hresp     = ipcvs_pkg::HRESP_OKAY;

   // Priority registers; masked storage keeps unimplemented bits at zero
   genvar r;
   generate
      for (r = 0; r < ipcvs_pkg::NUM_PRIO_REGS; r++)
      begin : g_prio
         always_ff @(posedge i_clk_sys)
         begin
            if (i_rst)
            begin
               prio_ff[r] <= ipcvs_pkg::PRIO_RST_ALL & ipcvs_pkg::PRIO_MASK[r];
            end
            else if (wr_en && (acc_ff.addr == 8'(r * 4)))
            begin
               prio_ff[r] <= i_hwdata[15:0] & ipcvs_pkg::PRIO_MASK[r];
            end
         end
      end
   endgenerate

   // Field extraction per source
   genvar s;
   generate
      for (s = 0; s < ipcvs_pkg::NUM_SRC; s++)
      begin : g_src
         assign src_prio[s] = prio_ff[ipcvs_pkg::SRC_REG[s]][ipcvs_pkg::SRC_LSB[s] +: 3];
         assign src_live[s] = i_src_req[s] && (src_prio[s] != ipcvs_pkg::PRIO_OFF);
      end
   endgenerate

   // Highest level wins; equal levels go to the lower source index
   always_comb
   begin
      nxt_irq = '0;
      for (int i = 0; i < ipcvs_pkg::NUM_SRC; i++)
      begin
         if (src_live[i] && (!nxt_irq.req || ({1'b0, src_prio[i]} > nxt_irq.level)))
         begin
            nxt_irq.req    = 1'b1;
            nxt_irq.level  = {1'b0, src_prio[i]};
            nxt_irq.vector = P_SRC_VECTOR[i];
         end
      end
   end

   assign new_irq = nxt_irq.req && (!irq_ff.req || (nxt_irq.vector != irq_ff.vector)
                    || (nxt_irq.level != irq_ff.level));

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         irq_ff <= '0;
      end
      else
      begin
         irq_ff <= nxt_irq;
      end
   end

   assign o_irq = irq_ff;

   // Pending status follows each newly presented interrupt
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         stat_level_ff <= '0;
         stat_vec_ff   <= '0;
      end
      else if (new_irq)
      begin
         stat_level_ff <= nxt_irq.level;
         stat_vec_ff   <= 7'(nxt_irq.vector - ipcvs_pkg::VEC_BASE);
      end
   end

   // Sticky events, write one to clear; a new set wins over the clear
   assign evt_set[ipcvs_pkg::EVT_NEW_VEC]  = new_irq;
   assign evt_set[ipcvs_pkg::EVT_DISABLED] = |(i_src_req & ~src_live);

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         evt_ff <= '0;
      end
      else if (wr_en && (acc_ff.addr == ipcvs_pkg::OFS_EVT_STATUS))
      begin
         evt_ff <= (evt_ff & ~i_hwdata[ipcvs_pkg::EVT_W-1:0]) | evt_set;
      end
      else
      begin
         evt_ff <= evt_ff | evt_set;
      end
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         evt_mask_ff <= '0;
      end
      else if (wr_en && (acc_ff.addr == ipcvs_pkg::OFS_EVT_MASK))
      begin
         evt_mask_ff <= i_hwdata[ipcvs_pkg::EVT_W-1:0];
      end
   end

   assign o_int = |(evt_ff & evt_mask_ff);

   // Read data is latched at the address phase and shown in the data phase
   always_comb
   begin
      nxt_rdata = '0;
      unique case (i_haddr[7:0])
         ipcvs_pkg::OFS_PRIO_CTRL_13:   nxt_rdata[15:0] = prio_ff[0];
         ipcvs_pkg::OFS_PRIO_CTRL_14:   nxt_rdata[15:0] = prio_ff[1];
         ipcvs_pkg::OFS_PRIO_CTRL_15:   nxt_rdata[15:0] = prio_ff[2];
         ipcvs_pkg::OFS_PRIO_CTRL_16:   nxt_rdata[15:0] = prio_ff[3];
         ipcvs_pkg::OFS_PRIO_CTRL_17:   nxt_rdata[15:0] = prio_ff[4];
         ipcvs_pkg::OFS_PENDING_STATUS:
         begin
            nxt_rdata[ipcvs_pkg::STAT_LEVEL_LSB +: ipcvs_pkg::LEVEL_W] = stat_level_ff;
            nxt_rdata[ipcvs_pkg::STAT_VEC_LSB +: ipcvs_pkg::VEC_W]     = stat_vec_ff;
         end
         ipcvs_pkg::OFS_EVT_STATUS:     nxt_rdata[ipcvs_pkg::EVT_W-1:0] = evt_ff;
         ipcvs_pkg::OFS_EVT_MASK:       nxt_rdata[ipcvs_pkg::EVT_W-1:0] = evt_mask_ff;
         default:                       nxt_rdata = '0;
      endcase
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         hrdata_ff <= '0;
      end
      else if (nxt_acc.valid && !i_hwrite)
      begin
         hrdata_ff <= nxt_rdata;
      end
   end

   assign o_hrdata = hrdata_ff;

endmodule

// ---- core/ipcvs_pkg.sv ----
// Package for the interrupt priority configuration and vector status block.
// Assumes one system clock; registers are reached over an AHB-Lite slave port.
package ipcvs_pkg;

   localparam int unsigned NUM_PRIO_REGS = 5;
   localparam int unsigned NUM_SRC       = 12;
   localparam int unsigned PRIO_W        = 3;
   localparam int unsigned REG_W         = 16;
   localparam int unsigned LEVEL_W       = 4;
   localparam int unsigned VEC_W         = 7;
   localparam int unsigned EVT_W         = 2;

   // Byte addresses, one aligned word each
   localparam logic [7:0] OFS_PRIO_CTRL_13    = 8'h00;
   localparam logic [7:0] OFS_PRIO_CTRL_14    = 8'h04;
   localparam logic [7:0] OFS_PRIO_CTRL_15    = 8'h08;
   localparam logic [7:0] OFS_PRIO_CTRL_16    = 8'h0c;
   localparam logic [7:0] OFS_PRIO_CTRL_17    = 8'h10;
   localparam logic [7:0] OFS_PENDING_STATUS  = 8'h14;
   localparam logic [7:0] OFS_EVT_STATUS      = 8'h18;
   localparam logic [7:0] OFS_EVT_MASK        = 8'h1c;

   // Implemented bits of priority_ctrl_13 .. priority_ctrl_17 (index 0 .. 4)
   localparam logic [NUM_PRIO_REGS-1:0][REG_W-1:0] PRIO_MASK =
      {16'h7777, 16'h0770, 16'h0070, 16'h0007, 16'h7777};
   // Every field starts at level 4
   localparam logic [REG_W-1:0]  PRIO_RST_ALL = 16'h4444;
   localparam logic [PRIO_W-1:0] PRIO_OFF     = 3'h0;

   // Per source: register index and field position
   localparam logic [NUM_SRC-1:0][2:0] SRC_REG =
      {3'h4, 3'h4, 3'h4, 3'h4, 3'h3, 3'h3, 3'h2, 3'h1, 3'h0, 3'h0, 3'h0, 3'h0};
   localparam logic [NUM_SRC-1:0][3:0] SRC_LSB =
      {4'hc, 4'h8, 4'h4, 4'h0, 4'h8, 4'h4, 4'h4, 4'h0, 4'hc, 4'h8, 4'h4, 4'h0};

   // Pending status layout
   localparam int unsigned STAT_LEVEL_LSB = 8;
   localparam int unsigned STAT_VEC_LSB   = 0;
   localparam logic [7:0]  VEC_BASE       = 8'h08;

   // Event bits
   localparam int unsigned EVT_NEW_VEC  = 0;
   localparam int unsigned EVT_DISABLED = 1;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic       HRESP_OKAY    = 1'b0;

   typedef struct packed {
      logic               req;
      logic [LEVEL_W-1:0] level;
      logic [7:0]         vector;
   } ipcvs_irq_type;

   typedef struct packed {
      logic       valid;
      logic       write;
      logic [7:0] addr;
   } ipcvs_acc_type;

endpackage

// ---- tb/ipcvs_cpu_model.sv ----
// Processor side: takes the vector of each presented request.
// Assumes the request struct is registered on i_clk_sys.
module ipcvs_cpu_model (
   input wire logic                i_clk_sys,
   input ipcvs_pkg::ipcvs_irq_type i_irq,
   output logic [7:0]              o_taken_vec
);
   timeunit 1ns;
   timeprecision 1ps;
   always_ff @(posedge i_clk_sys)
   begin
      if (i_irq.req)
         o_taken_vec <= i_irq.vector;
   end
endmodule

// ---- tb/ipcvs_ctrl_tb.sv ----
// Self-checking bench for the priority and vector status block.
// Acts as the one AHB-Lite master and drives the twelve request lines.
module ipcvs_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [11:0][7:0] VEC = {8'h33, 8'h32, 8'h31, 8'h30, 8'h2f, 8'h2e,
                                       8'h2d, 8'h2c, 8'h2b, 8'h2a, 8'h29, 8'h87};
   logic        i_clk_sys = 1'b0;
   logic        i_rst     = 1'b1;
   logic        hsel      = 1'b0;
   logic        hwrite    = 1'b0;
   logic [1:0]  htrans    = 2'h0;
   logic [7:0]  haddr     = 8'h00;
   logic [31:0] hwdata    = 32'h0;
   logic [11:0] req       = 12'h0;
   logic [31:0] hrdata, q;
   logic        hrdy, hresp, o_int;
   logic [7:0]  seen_vec;
   ipcvs_pkg::ipcvs_irq_type irq;
   int          error_cnt = 0;
   int          total_checks = 0;
   logic [7:0]  adr [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h1c, 8'h20};
   logic [15:0] wexp [8] = '{16'h7777, 16'h0007, 16'h0070, 16'h0770, 16'h7777, 0, 3, 0};
   logic [15:0] av [3] = '{16'h3005, 16'h5005, 16'h7005};
   logic [12:0] ae [3] = '{13'h1530, 13'h1530, 13'h1733};

   always #10 i_clk_sys = ~i_clk_sys;

   ipcvs_ctrl #(.P_SRC_VECTOR(VEC)) DUT (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_hsel(hsel),
      .i_haddr({24'h0, haddr}), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
      .i_hwdata(hwdata), .i_hready(hrdy), .o_hreadyout(hrdy), .o_hresp(hresp),
      .o_hrdata(hrdata), .i_src_req(req), .o_irq(irq), .o_int(o_int));
   ipcvs_cpu_model cpu (.i_clk_sys(i_clk_sys), .i_irq(irq), .o_taken_vec(seen_vec));

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge i_clk_sys);
      while (hrdy !== 1'b1) @(posedge i_clk_sys);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge i_clk_sys);
      while (hrdy !== 1'b1) @(posedge i_clk_sys);
      q = hrdata;
   endtask

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e)
      begin
         error_cnt++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   task automatic finish_test;
      $display("checks=%0d mismatches=%0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (3000) @(posedge i_clk_sys);
      error_cnt++;
      finish_test;
   end

   initial
   begin
      repeat (2) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      for (int i = 0; i < 8; i++)
      begin
         bus(1'b1, adr[i], 32'hffffffff);
         bus(1'b0, adr[i], 32'h0);
         chk(q, {16'h0, wexp[i]});
      end
      $display("test register map done");
      bus(1'b1, 8'h00, 32'h0);
      req <= 12'h001;
      for (int c = 7; c >= 0; c--)
      begin
         bus(1'b1, 8'h00, 32'(c));
         @(posedge i_clk_sys);
         #1;
         chk({31'h0, irq.req}, {31'h0, c != 0});
         if (c != 0)
         begin
            chk({19'h0, irq}, {19'h0, 1'b1, 4'(c), 8'h87});
            bus(1'b0, 8'h14, 32'h0);
            chk(q, {20'h0, 4'(c), 8'h7f});
            chk({24'h0, seen_vec}, 32'h87);
         end
      end
      $display("test priority codes done");
      req <= 12'h900;
      for (int i = 0; i < 3; i++)
      begin
         bus(1'b1, 8'h10, {16'h0, av[i]});
         @(posedge i_clk_sys);
         #1;
         chk({19'h0, irq}, {19'h0, ae[i]});
      end
      $display("test arbitration done");
      chk({31'h0, o_int}, 32'h1);
      bus(1'b1, 8'h1c, 32'h0);
      #1;
      chk({31'h0, o_int}, 32'h0);
      bus(1'b1, 8'h18, 32'h3);
      bus(1'b1, 8'h1c, 32'h1);
      #1;
      chk({31'h0, o_int}, 32'h0);
      // Drop the level 7 source so the winner changes and a new vector is presented
      req <= 12'h100;
      @(posedge i_clk_sys);
      #1;
      chk({31'h0, o_int}, 32'h1);
      $display("test interrupt done");
      req <= 12'h000;
      i_rst <= 1'b1;
      repeat (2) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      #1;
      chk({18'h0, o_int, irq}, 32'h0);
      for (int i = 0; i < 5; i++)
      begin
         bus(1'b0, adr[i], 32'h0);
         chk(q, {16'h0, 16'h4444 & wexp[i]});
      end
      $display("test reset done");
      finish_test;
   end
endmodule

// ---- tb/ipcvs_properties.sv ----
// Checker for the priority and vector status block.
// Bound to ipcvs_ctrl; sees its bus, request and interrupt ports only.
module ipcvs_properties (
   input wire logic                          i_clk_sys,
   input wire logic                          i_rst,
   input wire logic                          i_hsel,
   input wire logic [1:0]                    i_htrans,
   input wire logic                          i_hwrite,
   input wire logic                          i_hready,
   input wire logic                          o_hreadyout,
   input wire logic                          o_hresp,
   input wire logic [31:0]                   o_hrdata,
   input wire logic [ipcvs_pkg::NUM_SRC-1:0] i_src_req,
   input ipcvs_pkg::ipcvs_irq_type           o_irq,
   input wire logic                          o_int
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   a_bus_okay: assert property (o_hreadyout && o_hresp == 1'b0)
      else $error("bus slave not ready or not OKAY");
   a_reset_clear: assert property ($past(i_rst) |-> o_irq == '0 && !o_int)
      else $error("outputs not cleared by reset");
   a_idle_quiet: assert property (i_src_req == '0 |=> !o_irq.req)
      else $error("request forwarded with no source active");
   a_rose_cause: assert property ($rose(o_irq.req) |-> $past(|i_src_req))
      else $error("request raised without a cause");
   a_level_legal: assert property (o_irq.req |-> o_irq.level inside {[4'h1:4'h7]})
      else $error("forwarded level outside one to seven");
   a_upper_zero: assert property (o_hrdata[31:16] == 16'h0)
      else $error("upper read data not zero");
   a_rdata_hold: assert property (
      !(i_hsel && i_hready && i_htrans == 2'h2 && !i_hwrite) |=> $stable(o_hrdata))
      else $error("read data changed without a read");
   a_irq_settle: assert property (
      (!i_rst && $stable(i_src_req) && !(i_hsel && i_htrans == 2'h2
      && i_hwrite))[*3] |=> $stable(o_irq))
      else $error("request output moved with inputs quiet");
endmodule

bind ipcvs_ctrl ipcvs_properties u_props (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_hsel(i_hsel),
   .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready), .o_hreadyout(o_hreadyout),
   .o_hresp(o_hresp), .o_hrdata(o_hrdata), .i_src_req(i_src_req), .o_irq(o_irq), .o_int(o_int));
